// ---- hdl/tmo_pkg.sv ----
// Summary of operation
// - Code 75: counter 1 auto-reloads from low reload on first start bit.
// - Code 75: 16-bit counter loads high and mid, restarts each start bit.
// - Reload writes during a count only apply at the next load or counter 1 auto-reload.
// - Writing 00h to the configuration register stops every counter.
// - Code 7C: 24-bit chain loads all reloads, restarts each start bit.
// - Code 85 acts as 05; all counters halt after 12th ETU.
// - Code E5 acts as 65; counter 1 halts after 12th ETU.
// - Code F1 acts as 71; 16-bit counter halts after 12th ETU.
// - Code F5 acts as 75; both counters halt after 12th ETU.
// - Code 05 halts counters 2 and 3, counter 1 keeps running.
// - Code 65 starts 16-bit counter at once; expiry sets counter 3 flag.
// - Code 71 halts counter 1; 16-bit counter retriggers on start bits.
`default_nettype none
package tmo_pkg;
  // Register byte offsets
  localparam logic [7:0] CFG_OFF      = 8'h00;
  localparam logic [7:0] RLD_LOW_OFF  = 8'h04;
  localparam logic [7:0] RLD_MID_OFF  = 8'h08;
  localparam logic [7:0] RLD_HIGH_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF   = 8'h10;
  localparam logic [7:0] COUNT_OFF    = 8'h14;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RLD_RST = 8'h00;
  // Status bit positions
  localparam int ST_C1_EXP  = 0;
  localparam int ST_C3_EXP  = 1;
  localparam int ST_C1_RUN  = 2;
  localparam int ST_BIG_RUN = 3;
  // Configuration codes
  localparam logic [7:0] CODE_STOP    = 8'h00;
  localparam logic [7:0] CODE_C1_ONLY = 8'h05;
  localparam logic [7:0] CODE_16_NOW  = 8'h61;
  localparam logic [7:0] CODE_BOTH_NOW = 8'h65;
  localparam logic [7:0] CODE_24_NOW  = 8'h68;
  localparam logic [7:0] CODE_16_SB   = 8'h71;
  localparam logic [7:0] CODE_BOTH_SB = 8'h75;
  localparam logic [7:0] CODE_24_SB   = 8'h7C;
  localparam logic [7:0] CODE_C1_G12  = 8'h85;
  localparam logic [7:0] CODE_NOW_G12 = 8'hE5;
  localparam logic [7:0] CODE_16_G12  = 8'hF1;
  localparam logic [7:0] CODE_SB_G12  = 8'hF5;
  // Elementary time units before the guard halt
  localparam logic [3:0] GUARD_ETUS = 4'hC;
  localparam logic [3:0] GUARD_ONE  = 4'h1;
  typedef enum logic [1:0] {
    C1_HALT = 2'b00, C1_KEEP = 2'b01, C1_ON_SB = 2'b10
  } c1_mode_t;
  typedef enum logic [1:0] {
    BIG_HALT = 2'b00, BIG_NOW = 2'b01, BIG_ON_SB = 2'b10
  } big_mode_t;
  typedef enum logic [1:0] {
    G_IDLE = 2'b00, G_ARMED = 2'b01, G_COUNT = 2'b10, G_DONE = 2'b11
  } guard_state_t;
  typedef struct packed {
    c1_mode_t  c1;
    big_mode_t big;
    logic      wide;
    logic      g_c1;
    logic      g_big;
    logic      g_rx;
  } mode_t;
endpackage
`default_nettype wire

// ---- hdl/tmo_down_counter.sv ----
`default_nettype none
module tmo_down_counter #(
  parameter int W = 8
) (
  input  wire logic         hclk,        // Clock
  input  wire logic         hresetn,     // Async reset, low
  input  wire logic         halt,        // Stop counting
  input  wire logic         load,        // Start from load_val
  input  wire logic [W-1:0] load_val,    // Reload value
  input  wire logic         tick,        // One ETU elapsed
  input  wire logic         auto_reload, // Restart on expiry
  output logic              running,     // Counting
  output logic [W-1:0]      count,       // Current count
  output logic              expire       // Terminal count pulse
);
  localparam logic [W-1:0] ONE  = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);
  logic last;

  assign last = running && tick && (count == ONE);

  // Count and run state; halt beats load beats stepping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count   <= ZERO;
      running <= 1'b0;
      expire  <= 1'b0;
    end else begin
      expire <= !halt && !load && last;
      if (halt) begin
        running <= 1'b0;
      end else if (load) begin
        count   <= load_val;
        running <= (load_val != ZERO); // All-zero reload never runs
      end else if (last) begin
        count   <= auto_reload ? load_val : ZERO;
        running <= auto_reload && (load_val != ZERO);
      end else if (running && tick) begin
        count <= count - ONE;
      end
    end
  end

  a_step_per_etu: assert property (@(posedge hclk) disable iff (!hresetn)
    running && tick && !halt && !load && count > ONE
    |=> count == $past(count) - ONE)
    else $error("count did not step on ETU");
  a_expire_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    last && !halt && !load |=> expire ##1 !expire)
    else $error("terminal count pulse wrong");
endmodule
`default_nettype wire

// ---- hdl/tmo_ahb_slave.sv ----
`default_nettype none
module tmo_ahb_slave (
  input  wire logic        hclk,      // Clock
  input  wire logic        hresetn,   // Async reset, low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write
  input  wire logic [2:0]  hsize,     // Size, words only
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output logic             hreadyout, // Slave ready
  output logic             hresp,     // Always OKAY
  output logic [31:0]      hrdata,    // Read data
  output logic             wr_en,     // Write strobe
  output logic [7:0]       wr_addr,   // Write offset
  output logic [31:0]      wr_data,   // Write data
  output logic [7:0]       rd_addr,   // Read offset
  input  wire logic [31:0] rd_data    // Read value
);
  logic       take;
  logic       dph_wr_ff;
  logic       dph_rd_ff;
  logic [7:0] addr_ff;

  assign take = hsel && htrans[1] && hready;

  // Address phase capture; reads hold one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_ff <= 1'b0;
      dph_rd_ff <= 1'b0;
      addr_ff   <= 8'h00;
    end else begin
      dph_wr_ff <= take && hwrite;
      dph_rd_ff <= take && !hwrite;
      if (take) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // Read data sampled in the wait state, after any earlier write landed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (dph_rd_ff) begin
      hrdata <= rd_data;
    end
  end

  assign hreadyout = !dph_rd_ff;
  assign hresp     = 1'b0;
  assign wr_en     = dph_wr_ff;
  assign wr_addr   = addr_ff;
  assign wr_data   = hwdata;
  assign rd_addr   = addr_ff;

  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule
`default_nettype wire

// ---- hdl/card_io_timeout_counters.sv ----
`default_nettype none
module card_io_timeout_counters
  import tmo_pkg::*;
(
  input  wire logic        hclk,          // Clock, 20 MHz
  input  wire logic        hresetn,       // Async reset, low
  input  wire logic        hsel,          // AHB select
  input  wire logic [31:0] haddr,         // AHB address
  input  wire logic [1:0]  htrans,        // AHB transfer type
  input  wire logic        hwrite,        // AHB write
  input  wire logic [2:0]  hsize,         // AHB size
  input  wire logic [31:0] hwdata,        // AHB write data
  input  wire logic        hready,        // AHB ready in
  output logic             hreadyout,     // AHB ready out
  output logic             hresp,         // AHB response
  output logic [31:0]      hrdata,        // AHB read data
  input  wire logic        etu_tick,      // One pulse per ETU
  input  wire logic        start_bit,     // Start bit seen on I/O
  input  wire logic        start_bit_rx,  // That start bit is reception
  output logic             timeout_irq,   // Expiry interrupt, level
  output logic             counter1_expired_flag, // Counter 1 expired
  output logic             counter3_expired_flag  // Counter 3 expired
);
  logic         wr_en;
  logic [7:0]   wr_addr;
  logic [31:0]  wr_data;
  logic [7:0]   rd_addr;
  logic [31:0]  rd_data;
  logic [7:0]   timeout_config_ff;
  logic [7:0]   timeout_reload_low_ff;
  logic [7:0]   timeout_reload_mid_ff;
  logic [7:0]   timeout_reload_high_ff;
  logic         cfg_wr;
  logic         st_wr;
  mode_t        new_m;
  mode_t        cur_m;
  logic         c1_armed_ff;
  logic         c1_load;
  logic         c1_halt;
  logic         c1_running;
  logic [7:0]   c1_count;
  logic         c1_expire;
  logic         big_load;
  logic         big_halt;
  logic         big_wide;
  logic [23:0]  big_load_val;
  logic         big_running;
  logic [23:0]  big_count;
  logic         big_expire;
  guard_state_t guard_ff;
  guard_state_t nxt_guard;
  logic [3:0]   guard_cnt_ff;
  logic         guard_fire;
  logic         guard_sb;

  // Mode table for every configuration code
  function automatic mode_t decode_cfg(input logic [7:0] code);
    mode_t m;
    m = '{c1: C1_HALT, big: BIG_HALT, wide: 1'b0,
          g_c1: 1'b0, g_big: 1'b0, g_rx: 1'b0};
    unique case (code)
      CODE_C1_ONLY: m.c1 = C1_KEEP;
      CODE_16_NOW: m.big = BIG_NOW;
      CODE_BOTH_NOW: begin
        m.c1  = C1_ON_SB;
        m.big = BIG_NOW;
      end
      CODE_24_NOW: begin
        m.big  = BIG_NOW;
        m.wide = 1'b1;
      end
      CODE_16_SB: m.big = BIG_ON_SB;
      CODE_BOTH_SB: begin
        m.c1  = C1_ON_SB;
        m.big = BIG_ON_SB;
      end
      CODE_24_SB: begin
        m.big  = BIG_ON_SB;
        m.wide = 1'b1;
      end
      CODE_C1_G12: begin
        m.c1    = C1_KEEP;
        m.g_c1  = 1'b1;
        m.g_big = 1'b1;
        m.g_rx  = 1'b1;
      end
      CODE_NOW_G12: begin
        m.c1   = C1_ON_SB;
        m.big  = BIG_NOW;
        m.g_c1 = 1'b1;
      end
      CODE_16_G12: begin
        m.big   = BIG_ON_SB;
        m.g_big = 1'b1;
      end
      CODE_SB_G12: begin
        m.c1    = C1_ON_SB;
        m.big   = BIG_ON_SB;
        m.g_c1  = 1'b1;
        m.g_big = 1'b1;
      end
      default: m.c1 = C1_HALT; // Undefined codes stop all
    endcase
    return m;
  endfunction

  tmo_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  // Write decode and mode views
  assign cfg_wr = wr_en && (wr_addr == CFG_OFF);
  assign st_wr  = wr_en && (wr_addr == STATUS_OFF);
  assign new_m  = decode_cfg(wr_data[7:0]);
  assign cur_m  = decode_cfg(timeout_config_ff);

  // Configuration and reload registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timeout_config_ff      <= CFG_RST;
      timeout_reload_low_ff  <= RLD_RST;
      timeout_reload_mid_ff  <= RLD_RST;
      timeout_reload_high_ff <= RLD_RST;
    end else if (wr_en) begin
      unique case (wr_addr)
        CFG_OFF:      timeout_config_ff      <= wr_data[7:0];
        RLD_LOW_OFF:  timeout_reload_low_ff  <= wr_data[7:0];
        RLD_MID_OFF:  timeout_reload_mid_ff  <= wr_data[7:0];
        RLD_HIGH_OFF: timeout_reload_high_ff <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // Counter 1 waits for the first start bit after its mode is written
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c1_armed_ff <= 1'b0;
    end else if (cfg_wr) begin
      if (new_m.c1 == C1_ON_SB) begin
        c1_armed_ff <= 1'b1;
      end else if (new_m.c1 == C1_HALT) begin
        c1_armed_ff <= 1'b0;
      end
    end else if (start_bit) begin
      c1_armed_ff <= 1'b0;
    end
  end

  assign c1_load = c1_armed_ff && start_bit && !cfg_wr;
  assign c1_halt = (cfg_wr && new_m.c1 == C1_HALT)
                 || (guard_fire && cur_m.g_c1);

  // reload read live on each restart
  tmo_down_counter #(.W(8)) u_c1 (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .halt        (c1_halt),
    .load        (c1_load),
    .load_val    (timeout_reload_low_ff),
    .tick        (etu_tick),
    .auto_reload (1'b1),
    .running     (c1_running),
    .count       (c1_count),
    .expire      (c1_expire)
  );

  // 16 or 24 bit load, retriggered by each start bit in start-bit modes until the guard fires
  assign big_wide = cfg_wr ? new_m.wide : cur_m.wide;
  assign big_load_val = big_wide
    ? {timeout_reload_high_ff, timeout_reload_mid_ff, timeout_reload_low_ff}
    : {8'h00, timeout_reload_high_ff, timeout_reload_mid_ff};
  assign big_load = (cfg_wr && new_m.big == BIG_NOW)
    || (!cfg_wr && start_bit && cur_m.big == BIG_ON_SB
        && !(cur_m.g_big && guard_ff == G_DONE));
  // codes without the big counter halt it
  assign big_halt = (cfg_wr && new_m.big == BIG_HALT)
                  || (guard_fire && cur_m.g_big);

  // running count kept, reloads used at next load only
  tmo_down_counter #(.W(24)) u_big (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .halt        (big_halt),
    .load        (big_load),
    .load_val    (big_load_val),
    .tick        (etu_tick),
    .auto_reload (1'b0),
    .running     (big_running),
    .count       (big_count),
    .expire      (big_expire)
  );

  // guard qualifying start bit, reception only for 85h
  assign guard_sb = start_bit && (!cur_m.g_rx || start_bit_rx);
  assign guard_fire = (guard_ff == G_COUNT) && etu_tick && !cfg_wr
                    && (guard_cnt_ff == GUARD_ONE);

  // Guard sequencing
  always_comb begin
    nxt_guard = guard_ff;
    unique case (guard_ff)
      G_IDLE:  nxt_guard = G_IDLE;
      G_ARMED: if (guard_sb) begin
        nxt_guard = G_COUNT;
      end
      G_COUNT: if (guard_fire) begin
        nxt_guard = G_DONE;
      end
      G_DONE:  nxt_guard = G_DONE;
    endcase
    if (cfg_wr) begin
      nxt_guard = (new_m.g_c1 || new_m.g_big) ? G_ARMED : G_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      guard_ff     <= G_IDLE;
      guard_cnt_ff <= GUARD_ETUS;
    end else begin
      guard_ff <= nxt_guard;
      if (guard_ff == G_ARMED) begin
        guard_cnt_ff <= GUARD_ETUS;
      end else if (guard_ff == G_COUNT && etu_tick) begin
        guard_cnt_ff <= guard_cnt_ff - GUARD_ONE;
      end
    end
  end

  // Sticky expiry flags, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter1_expired_flag <= 1'b0;
      counter3_expired_flag <= 1'b0;
    end else begin
      counter1_expired_flag <= c1_expire || (counter1_expired_flag
        && !(st_wr && wr_data[ST_C1_EXP]));
      counter3_expired_flag <= big_expire || (counter3_expired_flag
        && !(st_wr && wr_data[ST_C3_EXP]));
    end
  end

  assign timeout_irq = counter1_expired_flag || counter3_expired_flag;

  // Read mux, unmapped offsets read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      CFG_OFF:      rd_data[7:0]  = timeout_config_ff;
      RLD_LOW_OFF:  rd_data[7:0]  = timeout_reload_low_ff;
      RLD_MID_OFF:  rd_data[7:0]  = timeout_reload_mid_ff;
      RLD_HIGH_OFF: rd_data[7:0]  = timeout_reload_high_ff;
      STATUS_OFF: begin
        rd_data[ST_C1_EXP]  = counter1_expired_flag;
        rd_data[ST_C3_EXP]  = counter3_expired_flag;
        rd_data[ST_C1_RUN]  = c1_running;
        rd_data[ST_BIG_RUN] = big_running;
      end
      COUNT_OFF:    rd_data[23:0] = big_count;
      default: ;
    endcase
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_c1_armed_write;
    cfg_wr && new_m.c1 == C1_ON_SB;
  endsequence
  sequence s_first_sb;
    start_bit && !cfg_wr && timeout_reload_low_ff != 8'h00;
  endsequence

  a_c1_sb_start: assert property (
    s_c1_armed_write ##1 s_first_sb |=> c1_running)
    else $error("counter 1 did not start on start bit");
  a_c1_flag_set: assert property (
    c1_expire |=> counter1_expired_flag && timeout_irq)
    else $error("counter 1 expiry flag missing");
  a_big_flag_set: assert property (
    big_expire |=> counter3_expired_flag && timeout_irq)
    else $error("counter 3 expiry flag missing");
  a_stop_all: assert property (
    cfg_wr && wr_data[7:0] == CODE_STOP |=> !c1_running && !big_running)
    else $error("stop code left a counter running");
  a_c05_big_off: assert property (
    cfg_wr && wr_data[7:0] == CODE_C1_ONLY |=> !big_running)
    else $error("code 05 left big counter running");
  a_c71_c1_off: assert property (
    cfg_wr && wr_data[7:0] == CODE_16_SB |=> !c1_running)
    else $error("code 71 left counter 1 running");
  a_retrig_load: assert property (
    big_load && !big_halt && !cfg_wr && cur_m.wide
    |=> big_count == {$past(timeout_reload_high_ff),
        $past(timeout_reload_mid_ff), $past(timeout_reload_low_ff)})
    else $error("24-bit retrigger load wrong");
  a_reload_ignored: assert property (
    big_running && wr_en && wr_addr == RLD_MID_OFF && !big_load
    && !big_halt && !etu_tick |=> big_count == $past(big_count))
    else $error("reload write disturbed running count");
  a_guard_halt_big: assert property (
    guard_fire && cur_m.g_big |=> !big_running)
    else $error("guard did not halt big counter");
  a_guard_halt_c1: assert property (
    guard_fire && cur_m.g_c1 |=> !c1_running)
    else $error("guard did not halt counter 1");
endmodule
`default_nettype wire

// ---- dv/card_io_model.sv ----
`default_nettype none
module card_io_model (
  input  wire logic hclk,        // Clock
  output logic      etu_tick,    // ETU pulse
  output logic      start_bit,   // Start bit pulse
  output logic      start_bit_rx // Reception qualifier
);
  timeunit 1ns;
  timeprecision 1ns;

  // Line idle at time zero
  initial begin
    etu_tick     = 1'b0;
    start_bit    = 1'b0;
    start_bit_rx = 1'b0;
  end

  // One start bit, qualifier inverted once the pulse is gone
  task automatic send_start(input logic rx);
    start_bit    <= 1'b1;
    start_bit_rx <= rx;
    @(posedge hclk);
    start_bit    <= 1'b0;
    start_bit_rx <= ~rx;
    @(posedge hclk);
  endtask

  task automatic etus(input int n);
    repeat (n) begin
      etu_tick <= 1'b1;
      @(posedge hclk);
      etu_tick <= 1'b0;
      repeat (3) @(posedge hclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
`default_nettype none
module tb_top
  import tmo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        hclk    = 1'b0;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [23:0] hi_addr;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  wire logic   hready;
  wire logic   etu_tick;
  wire logic   start_bit;
  wire logic   start_bit_rx;
  logic        timeout_irq;
  logic        counter1_expired_flag;
  logic        counter3_expired_flag;
  logic [31:0] rd;
  int          mismatches = 0;
  int          n_compared = 0;
  logic [7:0]  g_code [4] = '{CODE_C1_G12, CODE_NOW_G12, CODE_16_G12,
                              CODE_SB_G12};
  logic [7:0]  g_pre [4]  = '{CODE_BOTH_SB, CODE_STOP, CODE_STOP, CODE_STOP};
  logic [31:0] g_run [4]  = '{32'h4, 32'hC, 32'h8, 32'hC};
  logic [31:0] g_end [4]  = '{32'h0, 32'h8, 32'h0, 32'h0};

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  // 20 MHz clock
  always #25 hclk = ~hclk;

  card_io_timeout_counters card_io_timeout_counters_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .etu_tick(etu_tick), .start_bit(start_bit),
    .start_bit_rx(start_bit_rx), .timeout_irq(timeout_irq),
    .counter1_expired_flag(counter1_expired_flag),
    .counter3_expired_flag(counter3_expired_flag)
  );

  card_io_model card_io_model_i (
    .hclk(hclk), .etu_tick(etu_tick), .start_bit(start_bit),
    .start_bit_rx(start_bit_rx)
  );

  // Counts, verdict and end of run
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One AHB single transfer; read data kept in rd
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {hi_addr, a};
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  // Read and compare the masked word
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    end_of_test();
  end

  // Main sequence, bus idle and reset asserted at start
  initial begin
    hresetn <= 1'b0;
    hsel    <= 1'b0;
    haddr   <= 32'h0000_0000;
    htrans  <= 2'h0;
    hwrite  <= 1'b0;
    hsize   <= 3'h2;
    hwdata  <= 32'h0000_0000;
    hi_addr = 24'h00_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(CFG_OFF, 32'hFF, 32'h0);
    rchk(STATUS_OFF, 32'hF, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    wr(8'h18, 32'hA5);
    rchk(8'h18, 32'hFFFFFFFF, 32'h0);
    wr(RLD_LOW_OFF, 32'h3);
    wr(RLD_MID_OFF, 32'h5);
    wr(RLD_HIGH_OFF, 32'h0);
    wr(CFG_OFF, {24'h0, CODE_BOTH_SB});
    rchk(STATUS_OFF, 32'hC, 32'h0);
    card_io_model_i.send_start(1'b0);
    rchk(STATUS_OFF, 32'hC, 32'hC);
    rchk(COUNT_OFF, 32'hFFFFFF, 32'h5);
    card_io_model_i.etus(3);
    rchk(STATUS_OFF, 32'hF, 32'hD);
    chk({31'h0, counter1_expired_flag}, 32'h1);
    chk({31'h0, timeout_irq}, 32'h1);
    card_io_model_i.etus(2);
    rchk(STATUS_OFF, 32'hF, 32'h7);
    chk({31'h0, counter3_expired_flag}, 32'h1);
    card_io_model_i.send_start(1'b1);
    card_io_model_i.etus(2);
    // mid reload written while counting
    wr(RLD_MID_OFF, 32'h9);
    rchk(COUNT_OFF, 32'hFFFFFF, 32'h3);
    card_io_model_i.send_start(1'b0);
    rchk(COUNT_OFF, 32'hFFFFFF, 32'h9);
    wr(CFG_OFF, {24'h0, CODE_C1_ONLY});
    rchk(STATUS_OFF, 32'hC, 32'h4);
    wr(CFG_OFF, {24'h0, CODE_STOP});
    rchk(STATUS_OFF, 32'hC, 32'h0);
    wr(STATUS_OFF, 32'h3);
    rchk(STATUS_OFF, 32'h3, 32'h0);
    chk({31'h0, timeout_irq}, 32'h0);
    // 24-bit chain, upper address bits alias
    hi_addr = 24'h00_0100;
    wr(RLD_LOW_OFF, 32'h2);
    wr(RLD_MID_OFF, 32'h1);
    wr(RLD_HIGH_OFF, 32'h1);
    wr(CFG_OFF, {24'h0, CODE_24_SB});
    card_io_model_i.send_start(1'b1);
    rchk(COUNT_OFF, 32'hFFFFFF, 32'h010102);
    card_io_model_i.etus(1);
    rchk(COUNT_OFF, 32'hFFFFFF, 32'h010101);
    wr(CFG_OFF, {24'h0, CODE_STOP});
    wr(CFG_OFF, {24'h0, CODE_16_SB});
    card_io_model_i.send_start(1'b0);
    rchk(STATUS_OFF, 32'hC, 32'h8);
    rchk(COUNT_OFF, 32'hFFFFFF, 32'h0101);
    // Immediate 16-bit start, expiry on counter 3 flag
    wr(CFG_OFF, {24'h0, CODE_STOP});
    wr(RLD_MID_OFF, 32'h2);
    wr(RLD_HIGH_OFF, 32'h0);
    wr(STATUS_OFF, 32'h3);
    wr(CFG_OFF, {24'h0, CODE_BOTH_NOW});
    rchk(STATUS_OFF, 32'hC, 32'h8);
    card_io_model_i.etus(2);
    rchk(STATUS_OFF, 32'hB, 32'h2);
    // Guarded codes with long reloads
    wr(RLD_LOW_OFF, 32'hC8);
    wr(RLD_MID_OFF, 32'h0);
    wr(RLD_HIGH_OFF, 32'h1);
    foreach (g_code[i]) begin
      wr(CFG_OFF, {24'h0, g_pre[i]});
      card_io_model_i.send_start(1'b1);
      wr(CFG_OFF, {24'h0, g_code[i]});
      card_io_model_i.send_start(1'b1);
      rchk(STATUS_OFF, 32'hC, g_run[i]);
      card_io_model_i.etus(11);
      rchk(STATUS_OFF, 32'hC, g_run[i]);
      card_io_model_i.etus(1);
      rchk(STATUS_OFF, 32'hC, g_end[i]);
    end
    // Transmit start bit must not open the 85h guard
    wr(CFG_OFF, {24'h0, CODE_BOTH_SB});
    card_io_model_i.send_start(1'b0);
    wr(CFG_OFF, {24'h0, CODE_C1_G12});
    card_io_model_i.send_start(1'b0);
    card_io_model_i.etus(12);
    rchk(STATUS_OFF, 32'hC, 32'h4);
    card_io_model_i.send_start(1'b1);
    card_io_model_i.etus(12);
    rchk(STATUS_OFF, 32'hC, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
